// >>> verilog/sas_map.svh
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

`define SAS_ADDR_W 8
`define SAS_OFF_STATUS_CONTROL 8'h3C
`define SAS_OFF_RESULT 8'h40
`define SAS_OFF_CLOCK_SELECT 8'h44
`define SAS_OFF_IRQ_STATUS 8'h48
`define SAS_OFF_IRQ_MASK 8'h4C
`define SAS_OFF_PORT_DATA 8'h50
`define SAS_OFF_PORT_DIR 8'h54

`define SAS_SC_CONV_COMPLETE_FLAG_BIT 7
`define SAS_SC_CONV_IRQ_ENABLE_BIT 6
`define SAS_SC_CONTINUOUS_MODE_BIT_BIT 5
`define SAS_CH_W 5
`define SAS_CH_RESET 5'h1F
`define SAS_CH_POWER_OFF 5'h1F
`define SAS_CH_SUPPLY_REF 5'h1D
`define SAS_CH_GROUND_REF 5'h1E
`define SAS_CH_LAST_PIN 5'h03

`define SAS_PRE_LSB 5
`define SAS_PRE_W 3
`define SAS_PRE_RESET 3'h0

`define SAS_CONV_CYCLES 16
`define SAS_SAMPLE_CYCLES 8
`define SAS_RES_W 8

`define SAS_IRQ_DONE_BIT 0
`define SAS_IRQ_ABORT_BIT 1
`define SAS_IRQ_MASK_RESET 8'h03

`endif

// >>> verilog/sas_pkg.sv
package sas_pkg;
	typedef enum logic [2:0] {
		SAS_IDLE = 3'h1,
		SAS_SAMPLE = 3'h2,
		SAS_APPROX = 3'h4
	} sas_state_e;
	typedef logic [7:0] sas_byte_t;
endpackage

// >>> verilog/sas_top.sv
// How it works
// - Conversion lasts sixteen converter clock ticks.
// - Start on first tick after control write.
// - Eight-bit result updated at each completion.
// - Continuous bit repeats conversions, overwriting result.
// - Continuous clear: one conversion; reset clears bit.
// - No irq enable: flag set, cleared by read.
// - With irq enable flag never sets, reads zero.
// - Irq request at end; cleared by read/write.
// - Channel code selects pins or references.
// - All-ones channel powers off; reset value.
// - Selected pin forced analog; port writes ignored.
// - Taken pin reads zero or latch by direction.
// - Prescaler divides bus clock by 1..16.
// - Stop aborts conversion; restarts after stop ends.
// - Wait mode runs normally; irq wakes processor.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "sas_map.svh"

module sas_top #(
	parameter int RES_W = `SAS_RES_W,
	parameter int CONV_CYCLES = `SAS_CONV_CYCLES,
	parameter int SAMPLE_CYCLES = `SAS_SAMPLE_CYCLES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	output logic wake_req,
	input wire logic stop_mode,
	input wire logic wait_mode,
	input wire logic comp_in,
	output logic [RES_W-1:0] dac_code,
	output logic sample_en,
	output logic [4:0] selected_analog_input,
	output logic supply_ref_sel,
	output logic ground_ref_sel,
	output logic conv_power_off,
	input wire logic [3:0] port_pin_in,
	output logic [3:0] port_pin_out,
	output logic [3:0] port_pin_oe
);
	localparam int CNT_W = $clog2(CONV_CYCLES);

	// Bus handshake: one wait cycle per access
	logic ack_q;
	logic [31:0] rdata_q;
	wire logic req = avs_read | avs_write;
	wire logic wr_fire = avs_write & ack_q;
	wire logic rd_fire = avs_read & ack_q;
	wire logic lane0 = avs_byteenable[0];
	wire logic [7:0] wbyte = avs_writedata[7:0];

	wire logic hit_sc = avs_address == `SAS_OFF_STATUS_CONTROL;
	wire logic hit_res = avs_address == `SAS_OFF_RESULT;
	wire logic hit_clk = avs_address == `SAS_OFF_CLOCK_SELECT;
	wire logic hit_ist = avs_address == `SAS_OFF_IRQ_STATUS;
	wire logic hit_imk = avs_address == `SAS_OFF_IRQ_MASK;
	wire logic hit_pd = avs_address == `SAS_OFF_PORT_DATA;
	wire logic hit_dir = avs_address == `SAS_OFF_PORT_DIR;

	wire logic sc_wr = wr_fire & hit_sc & lane0;
	wire logic clk_wr = wr_fire & hit_clk & lane0;
	wire logic ist_wr = wr_fire & hit_ist & lane0;
	wire logic imk_wr = wr_fire & hit_imk & lane0;
	wire logic pd_wr = wr_fire & hit_pd & lane0;
	wire logic dir_wr = wr_fire & hit_dir & lane0;
	wire logic res_rd = rd_fire & hit_res;

	// Control registers
	logic conv_complete_flag_q;
	logic conv_irq_enable_q;
	logic continuous_mode_bit_q;
	logic [4:0] ch_q;
	logic [2:0] pre_q;
	sas_pkg::sas_byte_t ist_q;
	sas_pkg::sas_byte_t imk_q;
	logic [3:0] pdat_q;
	logic [3:0] pdir_q;
	logic [RES_W-1:0] res_q;

	// Converter state
	sas_pkg::sas_state_e st_q;
	logic [CNT_W-1:0] cnt_q;
	logic [RES_W-1:0] sar_q;
	logic [RES_W-1:0] trial_q;
	logic pend_q;
	logic [3:0] div_q;

	// Channel decode
	wire logic power_off = ch_q == `SAS_CH_POWER_OFF;
	wire logic pin_sel = ch_q <= `SAS_CH_LAST_PIN;
	wire logic [3:0] sel_mask = pin_sel ? (4'h1 << ch_q[1:0]) : 4'h0;

	// Prescaler decode
	wire logic [3:0] div_last = pre_q[2] ? 4'hF :
		pre_q[1:0] == 2'h0 ? 4'h0 :
		pre_q[1:0] == 2'h1 ? 4'h1 :
		pre_q[1:0] == 2'h2 ? 4'h3 : 4'h7;
	wire logic conv_tick = div_q >= div_last;

	wire logic active = !power_off && !stop_mode;
	wire logic busy = st_q != sas_pkg::SAS_IDLE;
	wire logic last_tick = cnt_q == CNT_W'(CONV_CYCLES - 1);
	wire logic done = busy && conv_tick && last_tick && active && !sc_wr;
	wire logic starting = conv_tick && active && !sc_wr &&
		((pend_q && !busy) || (done && continuous_mode_bit_q));
	wire logic abort = busy && stop_mode;
	wire logic [RES_W-1:0] sar_next = comp_in ? (sar_q | trial_q) : sar_q;
	wire logic [RES_W-1:0] final_res = (st_q == sas_pkg::SAS_APPROX) ? sar_next : sar_q;

	// Port read view of pins
	wire logic [3:0] pin_view;
	assign pin_view = (sel_mask & pdir_q & pdat_q) |
		(~sel_mask & ((pdir_q & pdat_q) | (~pdir_q & port_pin_in)));

	wire logic [7:0] sc_view = {conv_complete_flag_q & ~conv_irq_enable_q, conv_irq_enable_q, continuous_mode_bit_q, ch_q};
	wire logic [31:0] rd_mux =
		hit_sc ? {24'h0, sc_view} :
		hit_res ? 32'(res_q) :
		hit_clk ? {24'h0, pre_q, 5'h0} :
		hit_ist ? {24'h0, ist_q} :
		hit_imk ? {24'h0, imk_q} :
		hit_pd ? {28'h0, pin_view} :
		hit_dir ? {28'h0, pdir_q} : 32'h0;

	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata = rdata_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			rdata_q <= 32'h0;
		end else if (ce) begin
			ack_q <= req & ~ack_q;
			if (avs_read && !ack_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Status and control register, clock select register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			conv_irq_enable_q <= 1'b0;
			continuous_mode_bit_q <= 1'b0;
			ch_q <= `SAS_CH_RESET;
			pre_q <= `SAS_PRE_RESET;
		end else if (ce) begin
			if (sc_wr) begin
				conv_irq_enable_q <= wbyte[`SAS_SC_CONV_IRQ_ENABLE_BIT];
				continuous_mode_bit_q <= wbyte[`SAS_SC_CONTINUOUS_MODE_BIT_BIT];
				ch_q <= wbyte[4:0];
			end
			if (clk_wr) begin
				pre_q <= wbyte[`SAS_PRE_LSB +: `SAS_PRE_W];
			end
		end
	end

	// Completion flag, set beats clear
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			conv_complete_flag_q <= 1'b0;
		end else if (ce) begin
			if (done && !conv_irq_enable_q) begin
				conv_complete_flag_q <= 1'b1;
			end else if (res_rd || conv_irq_enable_q) begin
				conv_complete_flag_q <= 1'b0;
			end
		end
	end

	// Interrupt status and mask
	wire logic [7:0] ist_set = {6'h0, abort, done & conv_irq_enable_q};
	wire logic [7:0] ist_clr = (ist_wr ? wbyte : 8'h0) |
		{7'h0, res_rd | sc_wr};

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ist_q <= 8'h0;
			imk_q <= `SAS_IRQ_MASK_RESET;
		end else if (ce) begin
			ist_q <= ist_set | (ist_q & ~ist_clr);
			if (imk_wr) begin
				imk_q <= wbyte;
			end
		end
	end

	assign irq = |(ist_q & imk_q);
	assign wake_req = irq & wait_mode;

	// Port latches; the taken pin ignores writes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pdat_q <= 4'h0;
			pdir_q <= 4'h0;
		end else if (ce) begin
			if (pd_wr) begin
				pdat_q <= (pdat_q & sel_mask) | (wbyte[3:0] & ~sel_mask);
			end
			if (dir_wr) begin
				pdir_q <= (pdir_q & sel_mask) | (wbyte[3:0] & ~sel_mask);
			end
		end
	end

	assign port_pin_out = pdat_q;
	assign port_pin_oe = pdir_q & ~sel_mask;

	// Converter clock divider
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= 4'h0;
		end else if (ce) begin
			div_q <= conv_tick ? 4'h0 : div_q + 4'h1;
		end
	end

	// Start request: set by control write, kept through stop
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			pend_q <= 1'b0;
		end else if (ce) begin
			if (sc_wr) begin
				pend_q <= 1'b1;
			end else if (abort) begin
				pend_q <= 1'b1;
			end else if (starting || (power_off && !busy)) begin
				pend_q <= 1'b0;
			end
		end
	end

	// Sequencer: sample window then one bit per tick
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= sas_pkg::SAS_IDLE;
			cnt_q <= '0;
			sar_q <= '0;
			trial_q <= '0;
		end else if (ce) begin
			if (sc_wr || abort || (busy && power_off)) begin
				st_q <= sas_pkg::SAS_IDLE;
				cnt_q <= '0;
			end else if (starting) begin
				st_q <= sas_pkg::SAS_SAMPLE;
				cnt_q <= '0;
				sar_q <= '0;
				trial_q <= '0;
			end else if (busy && conv_tick) begin
				cnt_q <= cnt_q + CNT_W'(1);
				unique case (st_q)
					sas_pkg::SAS_SAMPLE: begin
						if (cnt_q == CNT_W'(SAMPLE_CYCLES - 1)) begin
							st_q <= sas_pkg::SAS_APPROX;
							trial_q <= {1'b1, {(RES_W-1){1'b0}}};
						end
					end
					sas_pkg::SAS_APPROX: begin
						sar_q <= sar_next;
						trial_q <= trial_q >> 1;
						if (last_tick) begin
							st_q <= sas_pkg::SAS_IDLE;
						end
					end
					default: begin
						st_q <= sas_pkg::SAS_IDLE;
					end
				endcase
			end
		end
	end

	// Result register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			res_q <= '0;
		end else if (ce && done) begin
			res_q <= final_res;
		end
	end

	assign dac_code = sar_q | trial_q;
	assign sample_en = st_q == sas_pkg::SAS_SAMPLE;
	assign selected_analog_input = ch_q;
	assign supply_ref_sel = ch_q == `SAS_CH_SUPPLY_REF;
	assign ground_ref_sel = ch_q == `SAS_CH_GROUND_REF;
	assign conv_power_off = power_off | stop_mode;
endmodule
`default_nettype wire

// >>> testbench/sas_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
module sas_cmp_model (
	input wire logic [7:0] dac_code,
	input wire logic [7:0] level,
	output logic comp_in
);
	// Ideal comparator, so a full approximation returns the level itself
	assign comp_in = level >= dac_code;
endmodule
`default_nettype wire

// >>> testbench/sas_top_chk.sv
`timescale 1ns/1ps
`default_nettype none
module sas_top_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic irq,
	input wire logic wake_req,
	input wire logic stop_mode,
	input wire logic wait_mode,
	input wire logic sample_en,
	input wire logic [4:0] selected_analog_input,
	input wire logic supply_ref_sel,
	input wire logic ground_ref_sel,
	input wire logic conv_power_off,
	input wire logic [3:0] port_pin_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_ctl_wr;
		avs_write && !avs_waitrequest && avs_address == 8'h3C;
	endsequence
	sequence s_armed;
		selected_analog_input != 5'h1F && !stop_mode;
	endsequence
	AST_START: assert property (s_ctl_wr ##1 s_armed[*2] |-> ##[0:20] sample_en)
		else $error("no sampling after control write");
	AST_WAKE: assert property (wake_req == (irq && wait_mode))
		else $error("wake request wrong");
	AST_PWR: assert property (selected_analog_input == 5'h1F |-> conv_power_off)
		else $error("power off missing");
	AST_SUP: assert property (supply_ref_sel == (selected_analog_input == 5'h1D))
		else $error("supply reference select wrong");
	AST_GND: assert property (ground_ref_sel == (selected_analog_input == 5'h1E))
		else $error("ground reference select wrong");
	AST_PIN: assert property (selected_analog_input < 5'h04 |->
		!port_pin_oe[selected_analog_input[1:0]]) else $error("taken pin still driven");
	AST_STOP: assert property (stop_mode [*2] |-> !sample_en && conv_power_off)
		else $error("converter active in stop");
	AST_HSK: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait state wrong");
endmodule
`default_nettype wire

// >>> testbench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk, rstn, avs_read, avs_write, avs_waitrequest, irq, wake_req, stop_mode, wait_mode;
	logic comp_in, sample_en, supply_ref_sel, ground_ref_sel, conv_power_off;
	logic [7:0] avs_address, dac_code, lvl, q;
	logic [31:0] avs_writedata, avs_readdata;
	logic [4:0] selected_analog_input;
	logic [3:0] port_pin_in, port_pin_out, port_pin_oe;
	logic [2:0] pc [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
	int mismatches, cmp_count, cyc, c, d;
	sas_top i_sas_top (.clk, .rstn, .ce(1'b1), .avs_address, .avs_read, .avs_write,
		.avs_byteenable(4'hF), .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .wake_req,
		.stop_mode, .wait_mode, .comp_in, .dac_code, .sample_en, .selected_analog_input,
		.supply_ref_sel, .ground_ref_sel, .conv_power_off, .port_pin_in, .port_pin_out, .port_pin_oe);
	sas_cmp_model i_sas_cmp_model (.dac_code, .level(lvl), .comp_in);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h000000, v};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic ck_irq(input logic e);
		@(negedge clk);
		chk("irq", e, irq);
		@(posedge clk);
	endtask
	task automatic wirq(input int lo, input int hi);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (irq !== 1'b1 && c < 400);
		chk("conversion time in range", 1'b1, c >= lo && c <= hi);
	endtask
	task automatic t_reset;
		rd(8'h3C, 8'h1F);
		rd(8'h44, 8'h00);
		rd(8'h4C, 8'h03);
		rd(8'h10, 8'h00);
		bus(1'b1, 8'h3C, 8'h1D);
		@(negedge clk);
		chk("supply ground select", 2'h2, {supply_ref_sel, ground_ref_sel});
		bus(1'b1, 8'h3C, 8'h1E);
		@(negedge clk);
		chk("supply ground select", 2'h1, {supply_ref_sel, ground_ref_sel});
		chk("selected input", 5'h1E, selected_analog_input);
		chk("power off", 1'b0, conv_power_off);
		bus(1'b1, 8'h3C, 8'h1F);
		@(negedge clk);
		chk("power off", 1'b1, conv_power_off);
	endtask
	task automatic t_port;
		bus(1'b1, 8'h54, 8'h00);
		bus(1'b1, 8'h50, 8'h0F);
		bus(1'b1, 8'h3C, 8'h00);
		rd(8'h50, 8'h0E);
		bus(1'b1, 8'h50, 8'h00);
		bus(1'b1, 8'h54, 8'h0F);
		@(negedge clk);
		chk("pin oe", 4'hE, port_pin_oe);
		chk("pin out", 4'h1, port_pin_out);
		rd(8'h50, 8'h00);
		bus(1'b1, 8'h3C, 8'h1F);
		bus(1'b1, 8'h54, 8'h0F);
		bus(1'b1, 8'h3C, 8'h00);
		rd(8'h50, 8'h01);
		bus(1'b1, 8'h3C, 8'h1F);
		bus(1'b0, 8'h40, 8'h00);
	endtask
	task automatic t_div;
		wait_mode <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			d = pc[i][2] ? 16 : (1 << pc[i]);
			lvl <= 8'h17 + 8'(i * 41);
			bus(1'b1, 8'h44, {pc[i], 5'h00});
			bus(1'b1, 8'h3C, 8'h40);
			wirq(16 * d, 17 * d + 1);
			chk("wake", 1'b1, wake_req);
			rd(8'h3C, 8'h40);
			bus(1'b1, 8'h4C, 8'h00);
			ck_irq(1'b0);
			bus(1'b1, 8'h4C, 8'h03);
			ck_irq(1'b1);
			rd(8'h40, lvl);
			ck_irq(1'b0);
		end
		wait_mode <= 1'b0;
	endtask
	task automatic t_restart;
		bus(1'b1, 8'h44, 8'h80);
		bus(1'b1, 8'h3C, 8'h40);
		repeat (100) @(posedge clk);
		bus(1'b1, 8'h3C, 8'h40);
		wirq(256, 273);
		bus(1'b1, 8'h48, 8'h01);
		ck_irq(1'b0);
	endtask
	task automatic t_cont;
		bus(1'b1, 8'h44, 8'h00);
		lvl <= 8'h5A;
		bus(1'b1, 8'h3C, 8'h21);
		repeat (40) @(posedge clk);
		rd(8'h40, 8'h5A);
		lvl <= 8'hA5;
		repeat (60) @(posedge clk);
		rd(8'h40, 8'hA5);
		bus(1'b1, 8'h3C, 8'h01);
		repeat (40) @(posedge clk);
		rd(8'h3C, 8'h81);
		rd(8'h40, 8'hA5);
		rd(8'h3C, 8'h01);
		repeat (40) @(posedge clk);
		rd(8'h3C, 8'h01);
	endtask
	task automatic t_stop;
		bus(1'b1, 8'h44, 8'h80);
		bus(1'b1, 8'h3C, 8'h00);
		repeat (40) @(posedge clk);
		stop_mode <= 1'b1;
		repeat (300) @(posedge clk);
		rd(8'h48, 8'h02);
		rd(8'h3C, 8'h00);
		bus(1'b1, 8'h48, 8'h02);
		ck_irq(1'b0);
		stop_mode <= 1'b0;
		repeat (300) @(posedge clk);
		rd(8'h3C, 8'h80);
	endtask
	task automatic end_of_test;
		$display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			end_of_test;
		end
	end
	initial begin
		rstn = 1'b0;
		{avs_read, avs_write, stop_mode, wait_mode} = 4'h0;
		avs_address = 8'h00;
		avs_writedata = 32'h00000000;
		port_pin_in = 4'hF;
		lvl = 8'h00;
		mismatches = 0;
		cmp_count = 0;
		cyc = 0;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		t_reset;
		t_port;
		t_div;
		t_restart;
		t_cont;
		t_stop;
		end_of_test;
	end
endmodule
bind sas_top sas_top_chk i_sas_top_chk (.clk, .rstn, .avs_address, .avs_read, .avs_write,
	.avs_waitrequest, .irq, .wake_req, .stop_mode, .wait_mode, .sample_en,
	.selected_analog_input, .supply_ref_sel, .ground_ref_sel, .conv_power_off, .port_pin_oe);
`default_nettype wire
